// *** logic/failsafe_params.svh ***
// Constants for the 32-point fail-safe output port.
// Assumes a 100 MHz core clock and the plain register port of the top module.
`ifndef FAILSAFE_PARAMS_SVH
`define FAILSAFE_PARAMS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_NS          10
`define TENTH_NS        100000000
`define LOSS_TICKS_DEF  10

// ----------------------------------------
// Address banks, reg_addr[9:8]
// ----------------------------------------
`define BANK_OUT        2'h0
`define BANK_IMAGE      2'h1
`define BANK_CTRL       2'h2

// ----------------------------------------
// Lanes inside the output and image banks
// ----------------------------------------
`define LANE_DWORD      8'h00
`define LANE_WORD_HI    4'h1
`define LANE_BYTE_HI    4'h2

// ----------------------------------------
// Control bank offsets
// ----------------------------------------
`define CTRL_KIND       8'h00
`define CTRL_DELAY      8'h04
`define CTRL_COMMIT     8'h08
`define CTRL_STATUS     8'h0C

// ----------------------------------------
// Status fields
// ----------------------------------------
`define ST_KIND_LSB     8
`define ST_ACTIVE       16
`define ST_LOST         17
`define ST_COMMIT       18

// ----------------------------------------
// Fail-safe kinds and reset values
// ----------------------------------------
`define KIND_OFF        2'h1
`define KIND_IMAGE      2'h2
`define KIND_HOLD       2'h3
`define KIND_RST        2'h1
`define DELAY_RST       8'h00
`define IMAGE_RST       32'h0000_0000

`endif

// *** logic/failsafe_pkg.sv ***
// Types shared by the fail-safe output port.
// Assumes failsafe_params.svh supplies the numeric constants.
package failsafe_pkg;

	typedef logic [1:0] fs_kind_t;

	typedef enum logic [1:0] {
		BANK_OUT,
		BANK_IMAGE,
		BANK_CTRL,
		BANK_NONE
	} bank_t;

endpackage

// *** logic/output_port_32_failsafe.sv ***
// 32-point on/off output port with staged fail-safe behaviour.
// Assumes a host on the same clock using the plain strobe register port.
//
// How it works
// - 32 points reachable as dword, two words, four bytes or single points.
// - After host silence and the delay, outputs take the fail-safe state.
// - Kind 1 forces off, kind 2 uses the image, kind 3 holds.
// - With kind 2 each point copies its image bit; otherwise image unused.
// - Delay counts tenths of a second, 0 to 255; zero means immediate.
// - Kind, delay and image take effect only on a commit.
// - Commit flag clears itself once the settings are transferred.
// - Image is written by point, byte, word or dword and is write-only.
`timescale 1ns/1ns
`include "failsafe_params.svh"

module output_port_32_failsafe #(
	parameter int unsigned TICK_CYCLES = `TENTH_NS / `CLK_NS,
	parameter int unsigned LOSS_TICKS  = `LOSS_TICKS_DEF
) (
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic        ce,
	input  wire logic [9:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output logic      [31:0] out_points,
	output logic             failsafe_active
);

	localparam int TCW = $clog2(TICK_CYCLES) + 1;
	localparam logic [TCW-1:0] TICK_LAST = TCW'(TICK_CYCLES - 1);
	localparam logic [8:0] LOSS = 9'(LOSS_TICKS);

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [31:0]            host_q, host_d;
	logic [31:0]            out_q, out_d;
	logic [31:0]            img_stage_q, img_stage_d;
	logic [31:0]            img_act_q, img_act_d;
	failsafe_pkg::fs_kind_t kind_stage_q, kind_stage_d;
	failsafe_pkg::fs_kind_t kind_act_q, kind_act_d;
	logic [7:0]             delay_stage_q, delay_stage_d;
	logic [7:0]             delay_act_q, delay_act_d;
	logic                   commit_q, commit_d;
	logic [TCW-1:0]         tick_cnt_q, tick_cnt_d;
	logic [8:0]             idle_q, idle_d;
	logic                   fs_q, fs_d;
	logic [31:0]            rdata_q, rdata_d;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	failsafe_pkg::bank_t bank;
	logic [7:0]          off;
	logic                lane_ok;
	logic [4:0]          shift;
	logic [31:0]         wmask;
	logic [31:0]         mask;
	logic [31:0]         lane_wdata;
	logic                host_seen;
	logic                tick;
	logic                lost;
	logic [8:0]          thr;

	assign off = reg_addr[7:0];

	always_comb begin
		if (reg_addr[9:8] == `BANK_OUT) begin
			bank = failsafe_pkg::BANK_OUT;
		end else if (reg_addr[9:8] == `BANK_IMAGE) begin
			bank = failsafe_pkg::BANK_IMAGE;
		end else if (reg_addr[9:8] == `BANK_CTRL) begin
			bank = failsafe_pkg::BANK_CTRL;
		end else begin
			bank = failsafe_pkg::BANK_NONE;
		end
	end

	// Lane layout: dword 0x00, words 0x10/0x14, bytes 0x20-0x2C, points 0x80+4p
	always_comb begin
		lane_ok = 1'b1;
		shift   = 5'h00;
		wmask   = 32'hFFFF_FFFF;
		if (off == `LANE_DWORD) begin
			shift = 5'h00;
		end else if (off[7:4] == `LANE_WORD_HI && off[3] == 1'b0 && off[1:0] == 2'h0) begin
			shift = {off[2], 4'h0};
			wmask = 32'h0000_FFFF;
		end else if (off[7:4] == `LANE_BYTE_HI && off[1:0] == 2'h0) begin
			shift = {off[3:2], 3'h0};
			wmask = 32'h0000_00FF;
		end else if (off[7] && off[1:0] == 2'h0) begin
			shift = off[6:2];
			wmask = 32'h0000_0001;
		end else begin
			lane_ok = 1'b0;
		end
	end

	assign mask       = wmask << shift;
	assign lane_wdata = (reg_wdata << shift) & mask;

	// Any strobe counts as proof of life, even to an unmapped address
	assign host_seen = reg_wr | reg_rd;
	assign tick      = (tick_cnt_q == TICK_LAST);
	assign lost      = (idle_q >= LOSS);
	assign thr       = LOSS + {1'b0, delay_act_q};

	// ----------------------------------------
	// Output selection, one mux per point
	// ----------------------------------------
	for (genvar i = 0; i < 32; i++) begin : g_point
		always_comb begin
			if (!fs_q) begin
				out_d[i] = host_q[i];
			end else if (kind_act_q == `KIND_IMAGE) begin
				out_d[i] = img_act_q[i];
			end else if (kind_act_q == `KIND_HOLD) begin
				out_d[i] = out_q[i];
			end else begin
				out_d[i] = 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		host_d        = host_q;
		img_stage_d   = img_stage_q;
		img_act_d     = img_act_q;
		kind_stage_d  = kind_stage_q;
		kind_act_d    = kind_act_q;
		delay_stage_d = delay_stage_q;
		delay_act_d   = delay_act_q;
		commit_d      = commit_q;
		rdata_d       = 32'h0000_0000;

		if (reg_wr && lane_ok && bank == failsafe_pkg::BANK_OUT) begin
			host_d = (host_q & ~mask) | lane_wdata;
		end
		if (reg_wr && lane_ok && bank == failsafe_pkg::BANK_IMAGE) begin
			img_stage_d = (img_stage_q & ~mask) | lane_wdata;
		end
		if (reg_wr && bank == failsafe_pkg::BANK_CTRL && off == `CTRL_KIND) begin
			kind_stage_d = reg_wdata[1:0];
		end
		if (reg_wr && bank == failsafe_pkg::BANK_CTRL && off == `CTRL_DELAY) begin
			delay_stage_d = reg_wdata[7:0];
		end

		// Transfer in the cycle after the commit write, then drop the flag
		if (commit_q) begin
			kind_act_d  = kind_stage_q;
			delay_act_d = delay_stage_q;
			img_act_d   = img_stage_q;
			commit_d    = 1'b0;
		end
		// A fresh commit in the clearing cycle wins; a zero write is ignored
		if (reg_wr && bank == failsafe_pkg::BANK_CTRL && off == `CTRL_COMMIT
				&& reg_wdata[0]) begin
			commit_d = 1'b1;
		end

		if (reg_rd && lane_ok && bank == failsafe_pkg::BANK_OUT) begin
			rdata_d = (host_q & mask) >> shift;
		end else if (reg_rd && bank == failsafe_pkg::BANK_CTRL && off == `CTRL_STATUS) begin
			rdata_d[7:0]                      = delay_act_q;
			rdata_d[`ST_KIND_LSB+1:`ST_KIND_LSB] = kind_act_q;
			rdata_d[`ST_ACTIVE]               = fs_q;
			rdata_d[`ST_LOST]                 = lost;
			rdata_d[`ST_COMMIT]               = commit_q;
		end
	end

	// ----------------------------------------
	// Loss watchdog and tenth-second divider
	// ----------------------------------------
	always_comb begin
		tick_cnt_d = tick_cnt_q + TCW'(1);
		idle_d     = idle_q;
		if (host_seen) begin
			tick_cnt_d = '0;
			idle_d     = 9'h000;
		end else begin
			if (tick) begin
				tick_cnt_d = '0;
			end
			// Saturates so a long silence never wraps back to normal
			if (tick && idle_q != 9'h1FF) begin
				idle_d = idle_q + 9'h001;
			end
		end
		fs_d = (idle_q >= thr);
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			host_q        <= 32'h0000_0000;
			out_q         <= 32'h0000_0000;
			img_stage_q   <= `IMAGE_RST;
			img_act_q     <= `IMAGE_RST;
			kind_stage_q  <= `KIND_RST;
			kind_act_q    <= `KIND_RST;
			delay_stage_q <= `DELAY_RST;
			delay_act_q   <= `DELAY_RST;
			commit_q      <= 1'b0;
			tick_cnt_q    <= '0;
			idle_q        <= 9'h000;
			fs_q          <= 1'b0;
			rdata_q       <= 32'h0000_0000;
		end else if (ce) begin
			host_q        <= host_d;
			out_q         <= out_d;
			img_stage_q   <= img_stage_d;
			img_act_q     <= img_act_d;
			kind_stage_q  <= kind_stage_d;
			kind_act_q    <= kind_act_d;
			delay_stage_q <= delay_stage_d;
			delay_act_q   <= delay_act_d;
			commit_q      <= commit_d;
			tick_cnt_q    <= tick_cnt_d;
			idle_q        <= idle_d;
			fs_q          <= fs_d;
			rdata_q       <= rdata_d;
		end
	end

	assign reg_rdata       = rdata_q;
	assign out_points      = out_q;
	assign failsafe_active = fs_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_dword_write: assert property (@(posedge core_clk) disable iff (!rstn)
		ce && reg_wr && reg_addr == {`BANK_OUT, `LANE_DWORD} |=> host_q == $past(reg_wdata))
		else $error("dword write not stored");

	chk_word1_point16: assert property (@(posedge core_clk) disable iff (!rstn)
		ce && reg_wr && reg_addr == 10'h014 |=> host_q[16] == $past(reg_wdata[0]))
		else $error("word 1 bit 0 did not reach point 16");

	chk_entry_after_wait: assert property (@(posedge core_clk) disable iff (!rstn)
		$rose(fs_q) |-> $past(idle_q) >= $past(thr))
		else $error("fail-safe entered before the delay");

	chk_kind_off: assert property (@(posedge core_clk) disable iff (!rstn)
		ce && fs_q && kind_act_q == `KIND_OFF |=> out_q == 32'h0000_0000)
		else $error("kind off left a point on");

	chk_kind_hold: assert property (@(posedge core_clk) disable iff (!rstn)
		ce && fs_q && kind_act_q == `KIND_HOLD |=> $stable(out_q))
		else $error("kind hold changed outputs");

	chk_image_drive: assert property (@(posedge core_clk) disable iff (!rstn)
		ce && fs_q && kind_act_q == `KIND_IMAGE |=> out_q == $past(img_act_q))
		else $error("outputs do not follow the image");

	chk_zero_delay: assert property (@(posedge core_clk) disable iff (!rstn)
		ce && delay_act_q == 8'h00 && idle_q >= LOSS |=> fs_q)
		else $error("zero delay did not engage at once");

	chk_commit_gate: assert property (@(posedge core_clk) disable iff (!rstn)
		!commit_q |=> $stable(kind_act_q) && $stable(delay_act_q) && $stable(img_act_q))
		else $error("active settings changed without commit");

	chk_commit_clear: assert property (@(posedge core_clk) disable iff (!rstn)
		ce && commit_q && !reg_wr |=> !commit_q)
		else $error("commit flag did not clear");

	chk_commit_zero: assert property (@(posedge core_clk) disable iff (!rstn)
		ce && !commit_q && reg_wr && reg_addr == {`BANK_CTRL, `CTRL_COMMIT}
		&& !reg_wdata[0] |=> !commit_q)
		else $error("zero write set the commit flag");

	chk_image_stage: assert property (@(posedge core_clk) disable iff (!rstn)
		ce && reg_wr && reg_addr == {`BANK_IMAGE, `LANE_DWORD}
		|=> img_stage_q == $past(reg_wdata))
		else $error("image dword write not staged");

	chk_comm_exit: assert property (@(posedge core_clk) disable iff (!rstn)
		ce && host_seen ##1 ce |=> !fs_q)
		else $error("host access did not leave fail-safe");

	chk_tick_wrap: assert property (@(posedge core_clk) disable iff (!rstn)
		ce && tick && !host_seen |=> tick_cnt_q == '0)
		else $error("tick divider did not wrap");

	cov_image_entry: cover property (@(posedge core_clk) disable iff (!rstn)
		$rose(fs_q) && kind_act_q == `KIND_IMAGE);
	cov_commit: cover property (@(posedge core_clk) disable iff (!rstn)
		$fell(commit_q));
	cov_exit: cover property (@(posedge core_clk) disable iff (!rstn)
		$fell(fs_q));

endmodule

// *** test/host_model.sv ***
// Host side of the register port: one-cycle strobes, read data taken a cycle later.
// Assumes the port sits on core_clk and never stalls the host.
`timescale 1ns/1ns

module host_model (
	input  wire logic        core_clk,
	output logic      [9:0]  reg_addr,
	output logic      [31:0] reg_wdata,
	output logic             reg_wr,
	output logic             reg_rd,
	input  wire logic [31:0] reg_rdata
);
	initial begin
		reg_addr  = 10'h000;
		reg_wdata = 32'h0000_0000;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
	end

	// ----------------------------------------
	// Bus cycles
	// ----------------------------------------
	// Staged settings, image forms and commit go out as plain writes
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr    <= 1'b0;
		// Released lines must not keep the old value
		reg_addr  <= ~a;
		reg_wdata <= ~d;
	endtask

	task automatic rd(input logic [9:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd   <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = reg_rdata;
	endtask
endmodule

// *** test/tb.sv ***
// Self-checking bench for the fail-safe output port.
// Assumes host_model drives the register port; short tick and loss counts.
`timescale 1ns/1ns
`include "failsafe_params.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end

module tb;
	localparam int TICKS = 4;
	localparam int LOSS  = 2;
	localparam logic [9:0] A_KIND = {`BANK_CTRL, `CTRL_KIND};
	localparam logic [9:0] A_DLY  = {`BANK_CTRL, `CTRL_DELAY};
	localparam logic [9:0] A_CMT  = {`BANK_CTRL, `CTRL_COMMIT};
	localparam logic [9:0] A_ST   = {`BANK_CTRL, `CTRL_STATUS};
	localparam logic [31:0] HOST  = 32'h1234_5678;
	localparam logic [31:0] IMG   = 32'hC300_01F0;

	logic        core_clk = 1'b0;
	logic        rstn     = 1'b0;
	logic        ce       = 1'b1;
	logic [9:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic [31:0] out_points;
	logic        failsafe_active;
	logic [31:0] r;
	logic [31:0] exp_out;
	int          fails     = 0;
	int          tests_run = 0;
	int          cnt;
	int          lo;

	always #5 core_clk = ~core_clk;

	output_port_32_failsafe #(.TICK_CYCLES(TICKS), .LOSS_TICKS(LOSS)) output_port_32_failsafe_inst (
		.core_clk        (core_clk),
		.rstn            (rstn),
		.ce              (ce),
		.reg_addr        (reg_addr),
		.reg_wdata       (reg_wdata),
		.reg_wr          (reg_wr),
		.reg_rd          (reg_rd),
		.reg_rdata       (reg_rdata),
		.out_points      (out_points),
		.failsafe_active (failsafe_active)
	);

	host_model host_model_inst (
		.core_clk  (core_clk),
		.reg_addr  (reg_addr),
		.reg_wdata (reg_wdata),
		.reg_wr    (reg_wr),
		.reg_rd    (reg_rd),
		.reg_rdata (reg_rdata)
	);

	task automatic conclude();
		if (fails == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Status minus the lost flag, which depends on idle time
	task automatic chk_status(input logic [31:0] e);
		host_model_inst.rd(A_ST, r);
		`CHK(r & 32'h0005_03FF, e)
	endtask

	initial begin
		#300000;
		fails++;
		conclude();
	end

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge core_clk);
		rstn <= 1'b1;
		chk_status(32'h0000_0100);
		`CHK(out_points, 32'h0000_0000)
		host_model_inst.wr(10'h000, 32'h0000_0000);
		host_model_inst.wr(10'h014, 32'h0000_0001);
		host_model_inst.rd(10'h000, r);
		`CHK(r, 32'h0001_0000)
		host_model_inst.wr(10'h028, 32'h0000_00FF);
		host_model_inst.wr(10'h0FC, 32'h0000_0001);
		host_model_inst.wr(10'h3FC, 32'hFFFF_FFFF);
		@(posedge core_clk);
		ce <= 1'b0;
		host_model_inst.wr(10'h000, 32'hFFFF_FFFF);
		ce <= 1'b1;
		host_model_inst.rd(10'h000, r);
		`CHK(r, 32'h80FF_0000)
		`CHK(out_points, 32'h80FF_0000)
		host_model_inst.rd(10'h02C, r);
		`CHK(r, 32'h0000_0080)
		host_model_inst.rd(10'h014, r);
		`CHK(r, 32'h0000_80FF)
		host_model_inst.rd(10'h0C0, r);
		`CHK(r, 32'h0000_0001)
		host_model_inst.rd(10'h3FC, r);
		`CHK(r, 32'h0000_0000)
		// Image built from every write form
		host_model_inst.wr(10'h100, 32'h0000_0000);
		host_model_inst.wr(10'h12C, 32'h0000_00C3);
		host_model_inst.wr(10'h110, 32'h0000_00F0);
		host_model_inst.wr(10'h1A0, 32'h0000_0001);
		host_model_inst.rd(10'h100, r);
		`CHK(r, 32'h0000_0000)
		host_model_inst.wr(A_KIND, 32'h0000_0002);
		host_model_inst.wr(A_DLY, 32'h0000_0005);
		chk_status(32'h0000_0100);
		host_model_inst.wr(A_CMT, 32'h0000_0000);
		chk_status(32'h0000_0100);
		host_model_inst.wr(A_CMT, 32'h0000_0001);
		chk_status(32'h0000_0205);
		for (int k = 1; k <= 3; k++) begin
			host_model_inst.wr(A_KIND, k);
			host_model_inst.wr(A_DLY, k - 1);
			host_model_inst.wr(A_CMT, 32'h0000_0001);
			host_model_inst.wr(10'h000, HOST);
			#1;
			cnt = 0;
			while (failsafe_active !== 1'b1 && cnt < 200) begin
				@(posedge core_clk);
				#1;
				cnt++;
			end
			lo = (LOSS + k - 1) * TICKS - 1;
			`CHK(cnt >= lo && cnt <= lo + 5, 1'b1)
			@(posedge core_clk);
			#1;
			exp_out = (k == 1) ? 32'h0000_0000 : (k == 2) ? IMG : HOST;
			`CHK(out_points, exp_out)
			// New host value: hold must keep the old one until the exit lands
			host_model_inst.wr(10'h000, ~HOST);
			@(posedge core_clk);
			#1;
			`CHK(out_points, exp_out)
			@(posedge core_clk);
			#1;
			`CHK(failsafe_active, 1'b0)
			`CHK(out_points, ~HOST)
		end
		// Mid-run reset restores outputs and active settings
		@(posedge core_clk);
		rstn <= 1'b0;
		@(posedge core_clk);
		rstn <= 1'b1;
		chk_status(32'h0000_0100);
		`CHK(out_points, 32'h0000_0000)
		conclude();
	end
endmodule
